// *** tscap_regs.vh ***
// Register map, field positions and timing constants of the capture timer
`ifndef TSCAP_REGS_VH
`define TSCAP_REGS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define TSC_ADDR_W        8
`define TSC_OFF_CTRL      8'h00
`define TSC_OFF_CNT_LOW   8'h04
`define TSC_OFF_CNT_HIGH  8'h08
`define TSC_OFF_RLD_LOW   8'h0c
`define TSC_OFF_RLD_HIGH  8'h10
`define TSC_OFF_CLK_CTRL  8'h14
`define TSC_OFF_IRQ_EN    8'h18

// ****************************************************************
// Control register fields
// ****************************************************************
`define TSC_B_EXT_CLK     0
`define TSC_B_CAP_SRC     1
`define TSC_B_RUN         2
`define TSC_B_SPLIT       3
`define TSC_B_CAP_EN      4
`define TSC_B_LOW_IEN     5
`define TSC_B_LOW_OVF     6
`define TSC_B_HIGH_OVF    7

// Clock control and interrupt enable fields
`define TSC_B_LOW_SYSTEM_CLOCK  0
`define TSC_B_HIGH_SYSTEM_CLOCK 1
`define TSC_B_TIMER_IEN   0

// ****************************************************************
// Reset values and count limits
// ****************************************************************
`define TSC_RST_BYTE      8'h00
`define TSC_RST_CLK       2'h0
`define TSC_RST_WORD      32'h00000000
`define TSC_BYTE_MAX      8'hff
`define TSC_WORD_MAX      16'hffff
`define TSC_WORD_ZERO     16'h0000
`define TSC_BYTE_ONE      8'h01
`define TSC_WORD_ONE      16'h0001

// ****************************************************************
// Tick dividers
// ****************************************************************
`define TSC_DIV_SYS       4'hb
`define TSC_DIV_SYS_RST   4'h0
`define TSC_DIV_SYS_ONE   4'h1
`define TSC_DIV_EXT       3'h7
`define TSC_DIV_EXT_RST   3'h0
`define TSC_DIV_EXT_ONE   3'h1

`endif

// *** tscap_tick.v ***
// Tick generator: system clock divided by 12 and external oscillator by 8
`include "tscap_regs.vh"

module tscap_tick (
	// Clock and reset
	input  wire sys_clk,
	input  wire rst,
	// External oscillator pin
	input  wire ext_osc,
	// Single-cycle ticks
	output reg  tick_div12,
	output reg  tick_ext8
);

	reg [3:0] div12_q;
	reg [2:0] div8_q;
	reg       ext_s1_q;
	reg       ext_s2_q;
	reg       ext_s3_q;
	wire      ext_rise;

	// ****************************************************************
	// System clock divided by 12
	// ****************************************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			div12_q    <= `TSC_DIV_SYS_RST;
			tick_div12 <= 1'b0;
		end else begin
			if (div12_q == `TSC_DIV_SYS) begin
				div12_q    <= `TSC_DIV_SYS_RST;
				tick_div12 <= 1'b1;
			end else begin
				div12_q    <= div12_q + `TSC_DIV_SYS_ONE;
				tick_div12 <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// External oscillator: synchronise, then count rising edges by 8
	// ****************************************************************
	assign ext_rise = ext_s2_q & ~ext_s3_q;

	always @(posedge sys_clk) begin
		if (rst) begin
			ext_s1_q  <= 1'b0;
			ext_s2_q  <= 1'b0;
			ext_s3_q  <= 1'b0;
			div8_q    <= `TSC_DIV_EXT_RST;
			tick_ext8 <= 1'b0;
		end else begin
			ext_s1_q  <= ext_osc;
			ext_s2_q  <= ext_s1_q;
			ext_s3_q  <= ext_s2_q;
			tick_ext8 <= ext_rise && (div8_q == `TSC_DIV_EXT);
			if (ext_rise) begin
				div8_q <= div8_q + `TSC_DIV_EXT_ONE;
			end
		end
	end

endmodule

// *** tscap_timer.v ***
// Capture timer top: APB registers, 16-bit and split counters, capture
//
// Our own choices: the APB register port and the placing of the registers.
`include "tscap_regs.vh"

module tscap_timer (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Oscillator and capture event pins
	input  wire        ext_osc,
	input  wire        sof_in,
	input  wire        lfo_in,
	// Timer interrupt request
	output reg         timer_irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	// Software-visible registers
	reg  [7:0]  ctrl_q;
	reg  [7:0]  cnt_low_q;
	reg  [7:0]  cnt_high_q;
	reg  [7:0]  rld_low_q;
	reg  [7:0]  rld_high_q;
	reg  [1:0]  clk_ctrl_q;
	reg         timer_ien_q;

	// Next values from the combinational blocks
	reg  [7:0]  cnt_low_d;
	reg  [7:0]  cnt_high_d;
	reg  [7:0]  rld_low_d;
	reg  [7:0]  rld_high_d;
	reg  [7:0]  ctrl_d;
	reg         set_high;
	reg         set_low;
	reg         irq_d;
	reg  [31:0] rdata_d;
	reg         map_hit;

	// Event pin synchronisers; the third flop holds the last level
	reg         sof_s1_q;
	reg         sof_s2_q;
	reg         sof_s3_q;
	reg         lfo_s1_q;
	reg         lfo_s2_q;
	reg         lfo_s3_q;

	// Decoded controls, ticks and events
	wire        tick_div12;
	wire        tick_ext8;
	wire        split;
	wire        cap_en;
	wire        run;
	wire        tick_low;
	wire        tick_high;
	wire        sof_rise;
	wire        lfo_rise;
	wire        cap_evt;
	wire        wr_done;
	wire [15:0] cnt_word;

	// ****************************************************************
	// Functions
	// ****************************************************************
	// System clock select wins; otherwise external /8 or system /12
	function sel_tick;
		input sys_sel;
		input ext_sel;
		input t_div12;
		input t_ext8;
		begin
			if (sys_sel) begin
				sel_tick = 1'b1;
			end else if (ext_sel) begin
				sel_tick = t_ext8;
			end else begin
				sel_tick = t_div12;
			end
		end
	endfunction

	// Write strobe for one register offset
	function wr_hit;
		input       done;
		input [7:0] addr;
		input [7:0] off;
		begin
			wr_hit = done && (addr == off);
		end
	endfunction

	// ****************************************************************
	// Tick sources
	// ****************************************************************
	// Both divided ticks are one-cycle pulses on the system clock
	tscap_tick u_tick (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.ext_osc    (ext_osc),
		.tick_div12 (tick_div12),
		.tick_ext8  (tick_ext8)
	);

	assign split     = ctrl_q[`TSC_B_SPLIT];
	assign cap_en    = ctrl_q[`TSC_B_CAP_EN];
	assign run       = ctrl_q[`TSC_B_RUN];
	assign cnt_word  = {cnt_high_q, cnt_low_q};

	assign tick_low  = sel_tick(clk_ctrl_q[`TSC_B_LOW_SYSTEM_CLOCK],
		ctrl_q[`TSC_B_EXT_CLK], tick_div12, tick_ext8);
	assign tick_high = sel_tick(clk_ctrl_q[`TSC_B_HIGH_SYSTEM_CLOCK],
		ctrl_q[`TSC_B_EXT_CLK], tick_div12, tick_ext8);

	// ****************************************************************
	// Capture event pins: synchronise and reduce to one-cycle pulses
	// ****************************************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			sof_s1_q <= 1'b0;
			sof_s2_q <= 1'b0;
			sof_s3_q <= 1'b0;
			lfo_s1_q <= 1'b0;
			lfo_s2_q <= 1'b0;
			lfo_s3_q <= 1'b0;
		end else begin
			sof_s1_q <= sof_in;
			sof_s2_q <= sof_s1_q;
			sof_s3_q <= sof_s2_q;
			lfo_s1_q <= lfo_in;
			lfo_s2_q <= lfo_s1_q;
			lfo_s3_q <= lfo_s2_q;
		end
	end

	// Rising edge only, so a pin held high captures once
	assign sof_rise = sof_s2_q & ~sof_s3_q;
	assign lfo_rise = lfo_s2_q & ~lfo_s3_q;
	assign cap_evt  = cap_en &
		(ctrl_q[`TSC_B_CAP_SRC] ? lfo_rise : sof_rise);

	// ****************************************************************
	// APB write strobe: taken at the completing access edge
	// ****************************************************************
	// A write lands only at the edge that completes the access
	assign wr_done = psel & penable & pready & pwrite;

	// ****************************************************************
	// Counter next state
	// ****************************************************************
	always @* begin
		cnt_low_d  = cnt_low_q;
		cnt_high_d = cnt_high_q;
		rld_low_d  = rld_low_q;
		rld_high_d = rld_high_q;
		set_high   = 1'b0;
		set_low    = 1'b0;
		if (!split) begin
			if (run && tick_low) begin
				if (cnt_word == `TSC_WORD_MAX) begin
					// Capture wraps to zero so reload keeps its capture
					if (cap_en) begin
						{cnt_high_d, cnt_low_d} = `TSC_WORD_ZERO;
					end else begin
						{cnt_high_d, cnt_low_d} = {rld_high_q, rld_low_q};
					end
					set_high = 1'b1;
				end else begin
					{cnt_high_d, cnt_low_d} = cnt_word + `TSC_WORD_ONE;
				end
				if (cnt_low_q == `TSC_BYTE_MAX) begin
					set_low = 1'b1;
				end
			end
		end else begin
			if (tick_low) begin
				if (cnt_low_q == `TSC_BYTE_MAX) begin
					cnt_low_d = cap_en ? `TSC_RST_BYTE : rld_low_q;
					set_low   = 1'b1;
				end else begin
					cnt_low_d = cnt_low_q + `TSC_BYTE_ONE;
				end
			end
			// high byte gated by run enable
			if (run && tick_high) begin
				if (cnt_high_q == `TSC_BYTE_MAX) begin
					cnt_high_d = cap_en ? `TSC_RST_BYTE : rld_high_q;
					set_high   = 1'b1;
				end else begin
					cnt_high_d = cnt_high_q + `TSC_BYTE_ONE;
				end
			end
		end
		// latch the running count into the reload pair
		if (cap_evt) begin
			rld_low_d  = cnt_low_q;
			rld_high_d = cnt_high_q;
			set_high   = 1'b1;
		end
		// Software writes to data registers override hardware updates
		if (wr_hit(wr_done, paddr, `TSC_OFF_CNT_LOW)) begin
			cnt_low_d = pwdata[7:0];
		end
		if (wr_hit(wr_done, paddr, `TSC_OFF_CNT_HIGH)) begin
			cnt_high_d = pwdata[7:0];
		end
		if (wr_hit(wr_done, paddr, `TSC_OFF_RLD_LOW)) begin
			rld_low_d = pwdata[7:0];
		end
		if (wr_hit(wr_done, paddr, `TSC_OFF_RLD_HIGH)) begin
			rld_high_d = pwdata[7:0];
		end
	end

	// ****************************************************************
	// Control register and flags: hardware set wins over software clear
	// ****************************************************************
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_hit(wr_done, paddr, `TSC_OFF_CTRL)) begin
			ctrl_d = pwdata[7:0];
		end
		// Hardware sets are ORed in after the write, so a set wins
		ctrl_d[`TSC_B_HIGH_OVF] = ctrl_d[`TSC_B_HIGH_OVF] | set_high;
		ctrl_d[`TSC_B_LOW_OVF]  = ctrl_d[`TSC_B_LOW_OVF] | set_low;
		// level request, with the timer interrupt enable set, while the high flag, or the low flag with its enable set, is pending
		irq_d = timer_ien_q & (ctrl_d[`TSC_B_HIGH_OVF] |
			(ctrl_d[`TSC_B_LOW_IEN] & ctrl_d[`TSC_B_LOW_OVF]));
	end

	// ****************************************************************
	// Read data decode
	// ****************************************************************
	always @* begin
		rdata_d = `TSC_RST_WORD;
		map_hit = 1'b1;
		case (paddr)
			`TSC_OFF_CTRL: begin
				rdata_d[7:0] = ctrl_q;
			end
			// Count bytes read separately; no atomic 16-bit read
			`TSC_OFF_CNT_LOW: begin
				rdata_d[7:0] = cnt_low_q;
			end
			`TSC_OFF_CNT_HIGH: begin
				rdata_d[7:0] = cnt_high_q;
			end
			`TSC_OFF_RLD_LOW: begin
				rdata_d[7:0] = rld_low_q;
			end
			`TSC_OFF_RLD_HIGH: begin
				rdata_d[7:0] = rld_high_q;
			end
			`TSC_OFF_CLK_CTRL: begin
				rdata_d[1:0] = clk_ctrl_q;
			end
			`TSC_OFF_IRQ_EN: begin
				rdata_d[`TSC_B_TIMER_IEN] = timer_ien_q;
			end
			// Unmapped offsets read zero and answer with an error
			default: begin
				map_hit = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Registers and APB answer
	// ****************************************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			ctrl_q      <= `TSC_RST_BYTE;
			cnt_low_q   <= `TSC_RST_BYTE;
			cnt_high_q  <= `TSC_RST_BYTE;
			rld_low_q   <= `TSC_RST_BYTE;
			rld_high_q  <= `TSC_RST_BYTE;
			clk_ctrl_q  <= `TSC_RST_CLK;
			timer_ien_q <= 1'b0;
			timer_irq   <= 1'b0;
			prdata      <= `TSC_RST_WORD;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			cnt_low_q  <= cnt_low_d;
			cnt_high_q <= cnt_high_d;
			rld_low_q  <= rld_low_d;
			rld_high_q <= rld_high_d;
			timer_irq  <= irq_d;
			// Clock control and interrupt enable change only by writes
			if (wr_hit(wr_done, paddr, `TSC_OFF_CLK_CTRL)) begin
				clk_ctrl_q <= pwdata[1:0];
			end
			if (wr_hit(wr_done, paddr, `TSC_OFF_IRQ_EN)) begin
				timer_ien_q <= pwdata[`TSC_B_TIMER_IEN];
			end
			// Setup cycle arms the answer for the first access cycle
			if (psel && !penable) begin
				pready  <= 1'b1;
				pslverr <= ~map_hit;
				prdata  <= pwrite ? `TSC_RST_WORD : rdata_d;
			end else begin
				// The answer stands for one cycle only
				pready  <= 1'b0;
				pslverr <= 1'b0;
				prdata  <= `TSC_RST_WORD;
			end
		end
	end

endmodule

// *** tscap_timer_assertions.sv ***
// Port-level assertions for the capture timer
module tscap_chk (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic        ext_osc,
	input wire logic        sof_in,
	input wire logic        lfo_in,
	input wire logic        timer_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wr;
	logic [7:0] ctrl_q;
	logic       ien_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	assign wr = psel & penable & pready & pwrite;
	// ****************************************************************
	// Shadows of the mode and enable bits
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_q <= 8'h00;
			ien_q  <= 1'b0;
		end else if (wr) begin
			if (paddr == 8'h00)
				ctrl_q <= pwdata[7:0];
			if (paddr == 8'h18)
				ien_q <= pwdata[0];
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	AST_SETUP_ANSWER: assert property (s_setup |=> s_answer)
		else $error("pready not one cycle after setup");
	AST_IDLE_QUIET: assert property (!psel |=> !pready)
		else $error("pready without select");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer with data");
	AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_IRQ_GATED: assert property (!ien_q |=> !timer_irq)
		else $error("interrupt while disabled");
	AST_FLAG_STICKY: assert property ($fell(timer_irq) |-> $past(wr))
		else $error("interrupt fell without a write");
	AST_SOF_IRQ: assert property (ctrl_q[4] && !ctrl_q[1] && ien_q
		&& $rose(sof_in) |-> ##[1:8] timer_irq)
		else $error("no interrupt after frame capture");
	AST_LFO_IRQ: assert property (ctrl_q[4] && ctrl_q[1] && ien_q
		&& $rose(lfo_in) |-> ##[1:8] timer_irq)
		else $error("no interrupt after oscillator capture");
endmodule
bind tscap_timer tscap_chk u_chk (.sys_clk(sys_clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ext_osc(ext_osc), .sof_in(sof_in),
	.lfo_in(lfo_in), .timer_irq(timer_irq));

// *** tscap_src.sv ***
// Far-side pin model: free oscillator and capture event sources
module tscap_src (
	// Clock
	input  wire logic sys_clk,
	// Pins
	output logic      ext_osc,
	output logic      sof_in,
	output logic      lfo_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q = 2'h0;
	initial begin
		ext_osc = 1'b0;
		sof_in = 1'b0;
		lfo_in = 1'b0;
	end
	// Oscillator toggles every three system clocks
	always @(posedge sys_clk) begin
		div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
		if (div_q == 2'h2)
			ext_osc <= ~ext_osc;
	end
	task automatic pulse(input logic low_freq_osc);
		@(posedge sys_clk);
		if (low_freq_osc)
			lfo_in <= 1'b1;
		else
			sof_in <= 1'b1;
		repeat (4) @(posedge sys_clk);
		lfo_in <= 1'b0;
		sof_in <= 1'b0;
	endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the capture timer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr, ext_osc, sof_in, lfo_in, timer_irq;
	logic [7:0]  rd;
	logic        er;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	always #5 sys_clk = ~sys_clk;
	tscap_src src (.sys_clk(sys_clk), .ext_osc(ext_osc), .sof_in(sof_in),
		.lfo_in(lfo_in));
	tscap_timer dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_osc(ext_osc), .sof_in(sof_in),
		.lfo_in(lfo_in), .timer_irq(timer_irq));
	// ****************************************************************
	// Bus and compare helpers
	// ****************************************************************
	task automatic chk(input string n, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic irq(input logic e);
		chk("irq", {7'h0, e}, {7'h0, timer_irq});
	endtask
	task automatic apb(input logic w, input logic [7:0] a, d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, e);
		apb(1'b0, a, 8'h00);
		chk(n, e, rd);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic s_regs;
		for (int a = 0; a <= 24; a += 4)
			rdc("reset value", a[7:0], 8'h00);
		apb(1'b1, 8'h1c, 8'h5a);
		chk("unmapped err", 8'h01, {7'h0, er});
		rdc("unmapped data", 8'h1c, 8'h00);
	endtask
	task automatic s_wrap16;
		logic [7:0] v;
		apb(1'b1, 8'h14, 8'h01);
		apb(1'b1, 8'h0c, 8'h34);
		apb(1'b1, 8'h10, 8'h12);
		apb(1'b1, 8'h04, 8'hfe);
		apb(1'b1, 8'h08, 8'hff);
		apb(1'b1, 8'h18, 8'h01);
		apb(1'b1, 8'h00, 8'h04);
		repeat (4) @(posedge sys_clk);
		irq(1'b1);
		rdc("wrap ctrl", 8'h00, 8'hc4);
		rdc("reload high", 8'h08, 8'h12);
		apb(1'b1, 8'h00, 8'h20);
		apb(1'b0, 8'h04, 8'h00);
		v = rd;
		repeat (20) @(posedge sys_clk);
		rdc("held low", 8'h04, v);
		irq(1'b0);
		apb(1'b1, 8'h04, 8'hff);
		apb(1'b1, 8'h00, 8'h24);
		repeat (4) @(posedge sys_clk);
		rdc("low wrap ctrl", 8'h00, 8'h64);
		repeat (30) @(posedge sys_clk);
		irq(1'b1);
		apb(1'b1, 8'h00, 8'h00);
		@(posedge sys_clk);
		irq(1'b0);
	endtask
	task automatic s_split;
		apb(1'b1, 8'h0c, 8'h80);
		apb(1'b1, 8'h08, 8'h00);
		apb(1'b1, 8'h04, 8'hf0);
		apb(1'b1, 8'h00, 8'h08);
		repeat (40) @(posedge sys_clk);
		rdc("split high", 8'h08, 8'h00);
		rdc("split ctrl", 8'h00, 8'h48);
		irq(1'b0);
		apb(1'b0, 8'h04, 8'h00);
		chk("split reload", 8'h01, {7'h0, rd[7]});
		apb(1'b1, 8'h00, 8'h28);
		repeat (140) @(posedge sys_clk);
		irq(1'b1);
		apb(1'b1, 8'h10, 8'h55);
		apb(1'b1, 8'h08, 8'hff);
		apb(1'b1, 8'h00, 8'h0c);
		repeat (16) @(posedge sys_clk);
		apb(1'b0, 8'h00, 8'h00);
		chk("high flag", 8'h01, {7'h0, rd[7]});
		irq(1'b1);
		apb(1'b0, 8'h08, 8'h00);
		chk("split high reload", 8'h01, {7'h0,
			rd == 8'h55 || rd == 8'h56});
	endtask
	task automatic s_ticks;
		apb(1'b1, 8'h14, 8'h00);
		for (int x = 0; x < 2; x++) begin
			apb(1'b1, 8'h00, 8'h00);
			apb(1'b1, 8'h04, 8'h00);
			apb(1'b1, 8'h08, 8'h00);
			apb(1'b1, 8'h00, {7'h2, x[0]});
			repeat (480) @(posedge sys_clk);
			apb(1'b0, 8'h04, 8'h00);
			chk("tick rate", 8'h01, {7'h0,
				rd >= (x ? 8'h09 : 8'h27) && rd <= (x ? 8'h0b : 8'h29)});
		end
	endtask
	task automatic s_capture;
		logic [7:0] v;
		logic [7:0] p;
		logic [7:0] c;
		p = 8'h00;
		apb(1'b1, 8'h14, 8'h01);
		apb(1'b1, 8'h0c, 8'h00);
		for (int x = 0; x < 2; x++) begin
			apb(1'b1, 8'h00, x ? 8'h1e : 8'h14);
			src.pulse(~x[0]);
			repeat (8) @(posedge sys_clk);
			irq(1'b0);
			src.pulse(x[0]);
			repeat (8) @(posedge sys_clk);
			irq(1'b1);
			apb(1'b0, 8'h0c, 8'h00);
			v = rd;
			apb(1'b0, 8'h04, 8'h00);
			c = rd - v;
			chk("capture age", 8'h0e, c);
			chk("captured", 8'h01, {7'h0, v != p});
			repeat (20) @(posedge sys_clk);
			rdc("one capture", 8'h0c, v);
			p = v;
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		s_regs();
		s_wrap16();
		s_split();
		s_ticks();
		s_capture();
		wrap_up();
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
endmodule
